// ===== hw/ida_addr_resolve.sv
// Turns a file field and access bit into a data address before indirection
`timescale 1ns/1ps
`default_nettype none
module ida_addr_resolve import ida_pkg::*; (
  input wire logic [7:0] file,
  input wire logic access,
  input wire logic ext_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [ADDR_W-1:0] base_ptr,
  output logic [ADDR_W-1:0] addr,
  output ida_mode_type mode
);

  // Banked, indexed literal offset or access space selection
  always_comb begin
    addr = {ACCESS_LOW_BANK, file};
    mode = IDA_MODE_ACCESS;
    if (access) begin
      addr = {bank_select_register, file}; // [R20] [R17]
      mode = IDA_MODE_BANKED;
    end else if (ext_en && file <= LIT_OFS_MAX) begin
      addr = base_ptr + {4'h0, file}; // [R15] [R16] [R21]
      mode = IDA_MODE_INDEXED;
    end else if (file > LIT_OFS_MAX) begin
      addr = {ACCESS_HIGH_BANK, file}; // [R19] [R14]
    end
  end

endmodule
`default_nettype wire

// ===== hw/ida_pointer_pair.sv
// One pointer pair with byte loads, full loads and whole-pair stepping
`timescale 1ns/1ps
`default_nettype none
module ida_pointer_pair import ida_pkg::*; #(
  parameter int WIDTH = ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  ida_ptr_if.pair bus
);

  if (WIDTH <= DATA_W || WIDTH > 2 * DATA_W) begin : g_bad_width
    $error("pointer width must exceed one byte and fit in two");
  end

  logic [WIDTH-1:0] value;
  logic [WIDTH-1:0] next_value;

  // Loads win over steps; steps carry across the whole pair
  always_comb begin
    next_value = value;
    if (bus.wr_full) begin
      next_value = bus.full_data;
    end else if (bus.wr_low) begin
      next_value = {value[WIDTH-1:DATA_W], bus.byte_data}; // [R12] [R13]
    end else if (bus.wr_high) begin
      next_value = {bus.byte_data[WIDTH-DATA_W-1:0], value[DATA_W-1:0]}; // [R1]
    end else if (bus.inc) begin
      next_value = value + 1'b1; // [R9] [R10]
    end else if (bus.dec) begin
      next_value = value - 1'b1; // [R9] [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= WIDTH'(PTR_RESET);
    end else begin
      value <= next_value;
    end
  end

  assign bus.value = value;

  wire logic no_load = !bus.wr_full && !bus.wr_low && !bus.wr_high;

  inc_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    no_load && bus.inc |=> value == WIDTH'($past(value) + 1'b1))
    else $error("pointer did not step up by one");
  dec_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    no_load && !bus.inc && bus.dec |=> value == WIDTH'($past(value) - 1'b1))
    else $error("pointer did not step down by one");
  hold_value_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    no_load && !bus.inc && !bus.dec |=> $stable(value))
    else $error("pointer changed without a command");

endmodule
`default_nettype wire

// ===== hw/ida_top.sv
// Data address generation with pointer pairs, indirect operands and APB access
//
// How it works
// R1 - Three pointer pairs, two bytes each, form 12-bit addresses; high nibble unused.
// R2 - Plain indirect operand accesses the pointed location, pointer unchanged.
// R3 - Indirect access uses the full 12-bit pointer, bank select ignored.
// R4 - Instructions naming indirect operands carry access bit zero.
// R5 - Post-decrement uses the pointer, then lowers it by one.
// R6 - Post-increment uses the pointer, then raises it by one.
// R7 - Pre-increment raises the pointer first, then uses it.
// R8 - Working offset targets pointer plus signed working value; nothing changes.
// R9 - Steps act on the whole pair with carry and borrow.
// R10 - Pointer steps touch no arithmetic status flags.
// R11 - Pointer aimed at a virtual operand: read gives 00h, write does nothing.
// R12 - Writing a pair through its own operand stores the value, no step.
// R13 - Pointer bytes are real registers; indirect access to other registers allowed.
// R14 - Extended set keeps memory map and pairs 0 and 1 unchanged.
// R15 - Indexed literal offset needs extended set, access bit 0, file at most 5Fh.
// R16 - Indexed target is file field plus pointer pair 2.
// R17 - Access bit 1, file 60h up, inherent and literal ops unchanged.
// R18 - Byte ops decode prefix, destination bit, access bit, file field.
// R19 - Extended, access bit 0, file 60h up reaches F60h to FFFh.
// R20 - Access bit 1 joins bank select with file field.
// R21 - Offset and indexed sums wrap within 12 bits.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ida_top import ida_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire logic [15:0] op_code,
  input wire logic op_write,
  input wire logic [7:0] op_wdata,
  input wire logic [7:0] working,
  output logic mem_valid,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_write,
  output logic [7:0] mem_wdata,
  output logic zero_read,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  output logic dest_file,
  output logic is_add_working
);

  // ****************************************
  // Declarations
  // ****************************************
  ida_ptr_if #(.W(ADDR_W)) ptr_bus [PAIRS] ();
  logic [ADDR_W-1:0] ptr_val [PAIRS];
  logic [3:0] bank_select_register;
  logic ext_en;
  ida_mode_type mem_mode;
  logic [3:0] next_bsr;
  logic next_ext_en;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_mem_valid;
  logic [ADDR_W-1:0] next_mem_addr;
  logic next_mem_write;
  logic next_zero_read;
  logic next_sfr_hit;
  logic [7:0] next_sfr_rdata;
  ida_mode_type next_mem_mode;
  logic [7:0] op_file;
  logic op_access;
  logic [5:0] op_prefix;
  logic [ADDR_W-1:0] ra;
  ida_mode_type ra_mode;
  ida_sfr_type s1;
  ida_sfr_type s2;
  ida_sfr_type sd;
  logic virt1;
  logic virt2;
  logic ptr_byte;
  logic self_write;
  logic [ADDR_W-1:0] pval;
  logic [ADDR_W-1:0] tgt;
  logic [31:0] apb_rd;
  logic apb_map;
  logic apb_setup;
  logic apb_wr;

  // ****************************************
  // Instruction fields
  // ****************************************
  // Byte-oriented layout: prefix, destination, access, file
  assign op_file = op_code[7:0]; // [R18]
  assign op_access = op_code[OP_ACCESS_BIT]; // [R18]
  assign op_prefix = op_code[15:OP_PREFIX_LSB]; // [R18]

  // Direct, access or indexed address before indirection
  ida_addr_resolve u_resolve (
    .file(op_file),
    .access(op_access),
    .ext_en(ext_en),
    .bank_select_register(bank_select_register),
    .base_ptr(ptr_val[INDEXED_PAIR]),
    .addr(ra),
    .mode(ra_mode)
  );

  // ****************************************
  // Indirection through pointer operands
  // ****************************************
  // Operand addresses sit in access space, so the access bit is clear
  // when software names them; a banked alias works the same way [R4]
  always_comb begin
    s1 = ida_sfr_decode(ra);
    virt1 = s1.hit && s1.slot >= SLOT_WOFS;
    pval = ptr_val[s1.pair];
    case (s1.slot)
      SLOT_WOFS: tgt = pval + {{4{working[7]}}, working}; // [R8] [R21]
      SLOT_PRE_INCREMENT_OPERAND: tgt = pval + 12'h001; // [R7]
      default: tgt = pval; // [R2] [R3] [R5] [R6]
    endcase
    s2 = ida_sfr_decode(tgt);
    virt2 = virt1 && s2.hit && s2.slot >= SLOT_WOFS; // [R11]
    sd = virt1 ? s2 : s1;
    ptr_byte = sd.hit && sd.slot < SLOT_WOFS && !virt2; // [R13]
    self_write = op_write && ptr_byte && virt1 && s2.pair == s1.pair; // [R12]
  end

  // ****************************************
  // Pointer pairs
  // ****************************************
  for (genvar g = 0; g < PAIRS; g++) begin : g_pair
    wire logic mine = op_valid && virt1 && s1.pair == 2'(g);
    wire logic byte_wr = op_valid && op_write && ptr_byte && sd.pair == 2'(g);

    // Steps from operands, byte loads from data writes, full loads from APB
    assign ptr_bus[g].inc = mine && !self_write &&
      (s1.slot == SLOT_POST_INCREMENT_OPERAND || s1.slot == SLOT_PRE_INCREMENT_OPERAND); // [R6] [R7] [R10]
    assign ptr_bus[g].dec = mine && !self_write && s1.slot == SLOT_POST_DECREMENT_OPERAND; // [R5] [R10]
    assign ptr_bus[g].wr_low = byte_wr && sd.slot == SLOT_LOW; // [R12] [R13]
    assign ptr_bus[g].wr_high = byte_wr && sd.slot == SLOT_HIGH; // [R12] [R13]
    assign ptr_bus[g].wr_full = apb_wr && paddr == APB_PTR0 + 12'(4 * g);
    assign ptr_bus[g].byte_data = op_wdata;
    assign ptr_bus[g].full_data = pwdata[ADDR_W-1:0];
    assign ptr_val[g] = ptr_bus[g].value;

    ida_pointer_pair #(.WIDTH(ADDR_W)) u_pair (
      .pclk(pclk),
      .presetn(presetn),
      .bus(ptr_bus[g])
    );
  end

  // ****************************************
  // Access outputs
  // ****************************************
  // Address, strobes and pointer byte read-back for the memory side
  always_comb begin
    next_mem_valid = op_valid;
    next_mem_addr = virt1 ? tgt : ra; // [R3]
    next_mem_write = op_valid && op_write && !virt2 && !ptr_byte; // [R11]
    next_zero_read = op_valid && virt2 && !op_write; // [R11]
    next_sfr_hit = op_valid && ptr_byte; // [R13]
    next_sfr_rdata = (sd.slot == SLOT_LOW) ? ptr_val[sd.pair][7:0] :
      {4'h0, ptr_val[sd.pair][ADDR_W-1:DATA_W]}; // [R1]
    next_mem_mode = virt1 ? IDA_MODE_INDIRECT : ra_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem_addr <= '0;
      mem_write <= 1'b0;
      mem_wdata <= 8'h00;
      zero_read <= 1'b0;
      sfr_hit <= 1'b0;
      sfr_rdata <= 8'h00;
      dest_file <= 1'b0;
      is_add_working <= 1'b0;
      mem_mode <= IDA_MODE_BANKED;
    end else begin
      mem_valid <= next_mem_valid;
      mem_addr <= next_mem_addr;
      mem_write <= next_mem_write;
      mem_wdata <= op_wdata;
      zero_read <= next_zero_read;
      sfr_hit <= next_sfr_hit;
      sfr_rdata <= next_sfr_rdata;
      dest_file <= op_code[OP_DEST_BIT]; // [R18]
      is_add_working <= op_prefix == ADD_WORKING_PREFIX; // [R18]
      mem_mode <= next_mem_mode;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;

  // Read mux and map check, one wait-free access phase
  always_comb begin
    apb_map = 1'b1;
    case (paddr)
      APB_PTR0: apb_rd = {20'h0, ptr_val[0]};
      APB_PTR1: apb_rd = {20'h0, ptr_val[1]};
      APB_PTR2: apb_rd = {20'h0, ptr_val[2]};
      APB_BSR: apb_rd = {28'h0, bank_select_register};
      APB_CTRL: apb_rd = {31'h0, ext_en};
      APB_STAT: apb_rd = {18'h0, mem_mode, mem_addr};
      default: begin
        apb_rd = 32'h0;
        apb_map = 1'b0;
      end
    endcase
    next_pready = apb_setup;
    next_pslverr = apb_setup && !apb_map;
    next_prdata = (apb_setup && !pwrite) ? apb_rd : 32'h0;
    next_bsr = bank_select_register;
    next_ext_en = ext_en;
    if (apb_wr && paddr == APB_BSR) begin
      next_bsr = pwdata[3:0];
    end
    if (apb_wr && paddr == APB_CTRL) begin
      next_ext_en = pwdata[CTRL_EXT_BIT]; // [R14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bank_select_register <= BSR_RESET;
      ext_en <= CTRL_EXT_RESET;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      bank_select_register <= next_bsr;
      ext_en <= next_ext_en;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  plain_indirect_a: assert property ( // [R2]
    op_valid && virt1 && s1.slot == SLOT_PLAIN && !virt2 |=> mem_valid && mem_addr == $past(pval))
    else $error("plain operand did not use the pointer");
  pre_increment_operand_addr_a: assert property ( // [R7]
    op_valid && virt1 && s1.slot == SLOT_PRE_INCREMENT_OPERAND |=> mem_addr == 12'($past(pval) + 12'h001))
    else $error("pre-increment used the old pointer");
  wofs_addr_a: assert property ( // [R8]
    op_valid && virt1 && s1.slot == SLOT_WOFS
    |=> mem_addr == 12'($past(pval) + {{4{$past(working[7])}}, $past(working)}))
    else $error("working offset address wrong");
  banked_addr_a: assert property ( // [R20]
    op_valid && op_access && !virt1 |=> mem_addr == {$past(bank_select_register), $past(op_file)})
    else $error("banked address wrong");
  indexed_addr_a: assert property ( // [R16]
    op_valid && !op_access && ext_en && op_file <= LIT_OFS_MAX && !virt1
    |=> mem_addr == 12'($past(ptr_val[INDEXED_PAIR]) + {4'h0, $past(op_file)}))
    else $error("indexed address wrong");
  null_access_a: assert property ( // [R11]
    op_valid && virt2 |=> !mem_write && (zero_read || $past(op_write)))
    else $error("pointer at operand did not null the access");
  apb_ready_a: assert property (
    apb_setup |=> pready ##1 !pready)
    else $error("ready is not a single cycle after setup");
  unmapped_err_a: assert property (
    apb_setup && paddr > APB_STAT |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped address was not refused");
  // Direct forms, pointer byte hits and mode tracking
  access_low_a: assert property ( // [R15]
    op_valid && !op_access && !ext_en && op_file <= LIT_OFS_MAX
    |=> mem_addr == {ACCESS_LOW_BANK, $past(op_file)})
    else $error("low access space address wrong");
  access_high_a: assert property ( // [R19]
    op_valid && !op_access && op_file > LIT_OFS_MAX && !virt1
    |=> mem_addr == {ACCESS_HIGH_BANK, $past(op_file)})
    else $error("high access space address wrong");
  sfr_byte_a: assert property ( // [R13]
    op_valid && ptr_byte |=> sfr_hit && !mem_write)
    else $error("pointer byte access reached memory");
  indirect_mode_a: assert property ( // [R3]
    op_valid && virt1 |=> mem_mode == IDA_MODE_INDIRECT)
    else $error("indirect access not flagged");

  post_increment_operand_seen_c: cover property (op_valid && virt1 && s1.slot == SLOT_POST_INCREMENT_OPERAND ##1 mem_valid);
  wofs_seen_c: cover property (op_valid && virt1 && s1.slot == SLOT_WOFS);
  indexed_seen_c: cover property (op_valid && ext_en && !op_access && op_file <= LIT_OFS_MAX);
  null_seen_c: cover property (zero_read);
  self_write_c: cover property (op_valid && self_write);

endmodule
`default_nettype wire

// ===== include/ida_pkg.sv
// Shared constants, types and decoding for the indirect data addressing block
package ida_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PAIRS = 3;

  // ****************************************
  // Pointer operand map in data space
  // ****************************************
  // Each pair owns seven consecutive locations starting at its base
  localparam logic [11:0] PAIR_BASE [PAIRS] = '{12'hFE9, 12'hFE1, 12'hFD9};
  localparam logic [11:0] PAIR_SPAN = 12'h006;
  localparam logic [2:0] SLOT_LOW = 3'h0;
  localparam logic [2:0] SLOT_HIGH = 3'h1;
  localparam logic [2:0] SLOT_WOFS = 3'h2;
  localparam logic [2:0] SLOT_PRE_INCREMENT_OPERAND = 3'h3;
  localparam logic [2:0] SLOT_POST_DECREMENT_OPERAND = 3'h4;
  localparam logic [2:0] SLOT_POST_INCREMENT_OPERAND = 3'h5;
  localparam logic [2:0] SLOT_PLAIN = 3'h6;
  localparam int INDEXED_PAIR = 2;

  // ****************************************
  // Access space and instruction fields
  // ****************************************
  localparam logic [7:0] LIT_OFS_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam int OP_ACCESS_BIT = 8;
  localparam int OP_DEST_BIT = 9;
  localparam int OP_PREFIX_LSB = 10;
  localparam logic [5:0] ADD_WORKING_PREFIX = 6'h09;

  // ****************************************
  // APB register map and reset values
  // ****************************************
  localparam logic [11:0] APB_PTR0 = 12'h000;
  localparam logic [11:0] APB_PTR1 = 12'h004;
  localparam logic [11:0] APB_PTR2 = 12'h008;
  localparam logic [11:0] APB_BSR = 12'h00C;
  localparam logic [11:0] APB_CTRL = 12'h010;
  localparam logic [11:0] APB_STAT = 12'h014;
  localparam int CTRL_EXT_BIT = 0;
  localparam int STAT_MODE_LSB = 12;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [3:0] BSR_RESET = 4'h0;
  localparam logic CTRL_EXT_RESET = 1'b0;

  typedef enum logic [1:0] {
    IDA_MODE_BANKED,
    IDA_MODE_ACCESS,
    IDA_MODE_INDEXED,
    IDA_MODE_INDIRECT
  } ida_mode_type;

  typedef struct packed {
    logic hit;
    logic [1:0] pair;
    logic [2:0] slot;
  } ida_sfr_type;

  // Tells whether an address falls on a pointer byte or operand
  function automatic ida_sfr_type ida_sfr_decode(input logic [ADDR_W-1:0] a);
    ida_sfr_type r;
    logic [ADDR_W-1:0] d;
    r = '0;
    d = '0;
    for (int i = 0; i < PAIRS; i++) begin
      d = a - PAIR_BASE[i];
      if (d <= PAIR_SPAN) begin
        r.hit = 1'b1;
        r.pair = 2'(i);
        r.slot = d[2:0];
      end
    end
    return r;
  endfunction

endpackage

// ===== include/ida_ptr_if.sv
// Command and value bundle between the top and one pointer pair
`timescale 1ns/1ps
`default_nettype none
interface ida_ptr_if #(parameter int W = 12);
  logic [W-1:0] value;
  logic inc;
  logic dec;
  logic wr_low;
  logic wr_high;
  logic wr_full;
  logic [7:0] byte_data;
  logic [W-1:0] full_data;
  modport pair (input inc, dec, wr_low, wr_high, wr_full, byte_data, full_data, output value);
  modport ctrl (output inc, dec, wr_low, wr_high, wr_full, byte_data, full_data, input value);
endinterface
`default_nettype wire

// ===== verif/ida_mem_model.sv
// Behavioural data memory standing behind the block's access port
`timescale 1ns/1ps
`default_nettype none
module ida_mem_model import ida_pkg::*; (
  input wire logic pclk,
  input wire logic mem_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_write,
  input wire logic [7:0] mem_wdata
);
  logic [7:0] mem [0:4095];

  // Known fill so that a dropped write can be seen
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'hA5;
    end
  end

  // Stores a write at the full effective address, any bank
  always @(posedge pclk) begin
    if (mem_valid && mem_write) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // Lets the bench look at a stored byte
  function automatic logic [7:0] peek(input logic [ADDR_W-1:0] a);
    return mem[a];
  endfunction
endmodule
`default_nettype wire

// ===== verif/ida_top_tb.sv
// Self-checking bench for the indirect data addressing block
`timescale 1ns/1ps
`default_nettype none
module ida_top_tb import ida_pkg::*;;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic op_valid = 1'h0;
  logic [15:0] op_code = 16'h0;
  logic op_write = 1'h0;
  logic [7:0] op_wdata = 8'h00;
  logic [7:0] working = 8'h00;
  logic mem_valid;
  logic [ADDR_W-1:0] mem_addr;
  logic mem_write;
  logic [7:0] mem_wdata;
  logic zero_read;
  logic sfr_hit;
  logic [7:0] sfr_rdata;
  logic dest_file;
  logic is_add_working;
  logic [5:0] pfx = 6'h00;
  logic dst = 1'h1;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int comparisons = 0;

  // 50 MHz clock
  always #10 pclk = ~pclk;

  ida_top ida_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_code(op_code), .op_write(op_write), .op_wdata(op_wdata), .working(working),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata),
    .zero_read(zero_read), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata), .dest_file(dest_file),
    .is_add_working(is_add_working));

  ida_mem_model ida_mem_model_i (.pclk(pclk), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_write(mem_write), .mem_wdata(mem_wdata));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Bus and instruction drivers
  // ****************************************
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) begin
        break;
      end
    end
    if (i == 16) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask

  // One data access; flags are valid, write, zero read, pointer byte hit
  task automatic op(input logic a, input logic [7:0] f, input logic wr, input logic [7:0] wd,
                    input logic [7:0] w, input logic [3:0] fl, input logic [11:0] ad);
    @(posedge pclk);
    op_valid <= 1'h1;
    op_code <= {pfx, dst, a, f};
    op_write <= wr;
    op_wdata <= wd;
    working <= w;
    @(posedge pclk);
    op_valid <= 1'h0;
    #1;
    check({8'h0, mem_wdata, mem_valid, mem_write, zero_read, sfr_hit, mem_addr}, {8'h0, wd, fl, ad});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    rreg(APB_PTR0, 32'h0);
    rreg(APB_PTR1, 32'h0);
    rreg(APB_PTR2, 32'h0);
    rreg(APB_BSR, 32'h0);
    rreg(APB_CTRL, 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    // Upper pointer bits are dropped; stepping carries and borrows
    wreg(APB_PTR0, 32'hFFFFF1FF);
    rreg(APB_PTR0, 32'h1FF);
    op(1'h0, 8'hEE, 1'h0, 8'h00, 8'h00, 4'h8, 12'h1FF);
    rreg(APB_PTR0, 32'h200);
    op(1'h0, 8'hED, 1'h0, 8'h00, 8'h00, 4'h8, 12'h200);
    rreg(APB_PTR0, 32'h1FF);
    wreg(APB_PTR1, 32'h0FF);
    op(1'h0, 8'hE4, 1'h0, 8'h00, 8'h00, 4'h8, 12'h100);
    rreg(APB_PTR1, 32'h100);
    // Plain indirect write ignores the bank select value
    wreg(APB_BSR, 32'h5);
    wreg(APB_PTR2, 32'h345);
    op(1'h0, 8'hDF, 1'h1, 8'h5A, 8'h00, 4'hC, 12'h345);
    rreg(APB_PTR2, 32'h345);
    check({24'h0, ida_mem_model_i.peek(12'h345)}, 32'h5A);
    // Working offset, signed and wrapping; then banked and low access space direct forms
    wreg(APB_PTR0, 32'hFFE);
    op(1'h0, 8'hEB, 1'h0, 8'h00, 8'h05, 4'h8, 12'h003);
    op(1'h0, 8'hEB, 1'h0, 8'h00, 8'hFF, 4'h8, 12'hFFD);
    rreg(APB_PTR0, 32'hFFE);
    op(1'h1, 8'h23, 1'h0, 8'h00, 8'h00, 4'h8, 12'h523);
    op(1'h0, 8'h10, 1'h0, 8'h00, 8'h00, 4'h8, 12'h010);
    // Extended set on: indexed window and unchanged cases
    wreg(APB_CTRL, 32'h1);
    op(1'h0, 8'h10, 1'h0, 8'h00, 8'h00, 4'h8, 12'h355);
    rreg(APB_STAT, 32'h00002355);
    op(1'h0, 8'h5F, 1'h0, 8'h00, 8'h00, 4'h8, 12'h3A4);
    op(1'h0, 8'h60, 1'h0, 8'h00, 8'h00, 4'h8, 12'hF60);
    op(1'h1, 8'h10, 1'h0, 8'h00, 8'h00, 4'h8, 12'h510);
    op(1'h0, 8'hEF, 1'h0, 8'h00, 8'h00, 4'h8, 12'hFFE);
    wreg(APB_PTR2, 32'hFF0);
    op(1'h0, 8'h5F, 1'h0, 8'h00, 8'h00, 4'h8, 12'h04F);
    wreg(APB_CTRL, 32'h0);
    // Pointer aimed at another pair's operand
    wreg(APB_PTR0, 32'hFE7);
    op(1'h0, 8'hEF, 1'h0, 8'h00, 8'h00, 4'hA, 12'hFE7);
    op(1'h0, 8'hEF, 1'h1, 8'h33, 8'h00, 4'h8, 12'hFE7);
    repeat (2) @(posedge pclk);
    check({24'h0, ida_mem_model_i.peek(12'hFE7)}, 32'hA5);
    // Writing a pair through its own operand stores without a step
    wreg(APB_PTR2, 32'hFD9);
    op(1'h0, 8'hDD, 1'h1, 8'h42, 8'h00, 4'h9, 12'hFD9);
    rreg(APB_PTR2, 32'hF42);
    // Pointer bytes as real registers
    op(1'h0, 8'hE9, 1'h1, 8'h77, 8'h00, 4'h9, 12'hFE9);
    rreg(APB_PTR0, 32'hF77);
    op(1'h0, 8'hEA, 1'h0, 8'h00, 8'h00, 4'h9, 12'hFEA);
    check({24'h0, sfr_rdata}, 32'h0F);
    // Byte op fields decoded
    pfx <= 6'h09;
    op(1'h0, 8'h10, 1'h0, 8'h00, 8'h00, 4'h8, 12'h010);
    check({30'h0, dest_file, is_add_working}, 32'h3);
    pfx <= 6'h00;
    dst <= 1'h0;
    op(1'h0, 8'h10, 1'h0, 8'h00, 8'h00, 4'h8, 12'h010);
    check({30'h0, dest_file, is_add_working}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
